// ### src/trcc_pkg.sv
// Package with register map, field layout and timing counts for the timer capture block.
package trcc_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned NUM_PIN = 9;
  localparam int unsigned FILT_CYC = 4;
  localparam int unsigned FILT_W = $clog2(FILT_CYC);
  localparam int unsigned AW = 10;
  localparam logic [7:0] IDX_CAPEF = 8'h92;
  localparam logic [7:0] IDX_EDGE = 8'h93;
  localparam logic [7:0] IDX_FILT = 8'h94;
  localparam logic [7:0] IDX_CTRL = 8'hc8;
  localparam logic [7:0] IDX_MODE = 8'hc9;
  localparam logic [7:0] IDX_RCL = 8'hca;
  localparam logic [7:0] IDX_RCH = 8'hcb;
  localparam logic [7:0] IDX_CNTL = 8'hcc;
  localparam logic [7:0] IDX_CNTH = 8'hcd;
  localparam logic [7:0] IDX_PSA = 8'hf1;
  localparam logic [7:0] IDX_PSB = 8'hf2;
  localparam logic [7:0] IDX_IEN = 8'hf8;
  localparam logic [7:0] IDX_RES_L [NUM_CH] = '{8'he4, 8'he6, 8'hed};
  localparam logic [7:0] IDX_RES_H [NUM_CH] = '{8'he5, 8'he7, 8'hee};
  localparam int unsigned CTRL_MODE = 0;
  localparam int unsigned CTRL_RUN = 2;
  localparam int unsigned CTRL_FLAG = 7;
  localparam int unsigned MODE_RELOAD_ENABLE = 7;
  localparam int unsigned MODE_CAPCLR = 3;
  localparam int unsigned MODE_CMPCLR = 2;
  localparam int unsigned MODE_TRIG = 0;
  localparam int unsigned CAP_EN_LSB = 4;
  localparam int unsigned CAP_FLAG_LSB = 0;
  localparam int unsigned FILT_EN_LSB = 4;
  localparam int unsigned IEN_GLOBAL = 0;
  localparam int unsigned IEN_CAP = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] CNT_CLEAR = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [3:0] PIN_SEL_MAX = 4'h8;
  localparam logic [1:0] TRIG_OVF = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TRCC_EDGE_FALL = 2'h0,
    TRCC_EDGE_RISE = 2'h1,
    TRCC_EDGE_BOTH = 2'h2,
    TRCC_EDGE_RSVD = 2'h3
  } trcc_edge_t;
endpackage

// ### src/trcc_timer_capture.sv
// Timer with reload, compare and three-channel input capture behind an AXI4-Lite slave.
//
// Decided for this implementation: the AXI4-Lite slave port.
module trcc_timer_capture
  import trcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PIN-1:0] capture_pin,
  output logic capture_irq
);

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [7:0] wa_idx_reg;
  logic [7:0] wdata_reg;
  logic wstrb_reg;
  logic [7:0] ctrl_reg, mode_reg;
  logic [15:0] rcmp_reg, cnt_reg, cnt_next;
  logic [NUM_CH-1:0] cap_en_reg, cap_flag_reg, filt_en_reg;
  logic [2*NUM_CH-1:0] edge_sel_reg;
  logic [7:0] psel_a_reg;
  logic [3:0] psel_b_reg;
  logic [1:0] ien_reg;
  logic irq_reg;
  logic [NUM_PIN-1:0] pin_s1_reg, pin_s2_reg;
  logic [15:0] res_reg [NUM_CH];
  logic [NUM_CH-1:0] sel_pin, f_lvl, cap_ev;

  // Write path: address and data are held until both arrived and the response is free.
  wire aw_hs = s_axi_awvalid & awready_reg;
  wire w_hs = s_axi_wvalid & wready_reg;
  wire wr_go = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire wr_lane = wr_go & wstrb_reg;
  wire ar_hs = s_axi_arvalid & arready_reg;
  wire [7:0] ar_idx = s_axi_araddr[AW-1:2];

  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = wr_lane && (wa_idx_reg == idx);
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IDX_CAPEF) || (idx == IDX_EDGE) || (idx == IDX_FILT) ||
      (idx == IDX_CTRL) || (idx == IDX_MODE) || (idx == IDX_RCL) ||
      (idx == IDX_RCH) || (idx == IDX_CNTL) || (idx == IDX_CNTH) ||
      (idx == IDX_PSA) || (idx == IDX_PSB) || (idx == IDX_IEN) ||
      (idx == IDX_RES_L[0]) || (idx == IDX_RES_H[0]) ||
      (idx == IDX_RES_L[1]) || (idx == IDX_RES_H[1]) ||
      (idx == IDX_RES_L[2]) || (idx == IDX_RES_H[2]);
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    logic [7:0] v;
    v = RST_BYTE;
    unique case (idx)
      IDX_CAPEF: v = {1'b0, cap_en_reg, 1'b0, cap_flag_reg};
      IDX_EDGE: v = {2'b00, edge_sel_reg};
      IDX_FILT: v = {1'b0, filt_en_reg, 4'h0};
      IDX_CTRL: v = ctrl_reg;
      IDX_MODE: v = mode_reg;
      IDX_RCL: v = rcmp_reg[7:0];
      IDX_RCH: v = rcmp_reg[15:8];
      IDX_CNTL: v = cnt_reg[7:0];
      IDX_CNTH: v = cnt_reg[15:8];
      IDX_PSA: v = psel_a_reg;
      IDX_PSB: v = {4'h0, psel_b_reg};
      IDX_IEN: v = {6'h00, ien_reg};
      IDX_RES_L[0]: v = res_reg[0][7:0];
      IDX_RES_H[0]: v = res_reg[0][15:8];
      IDX_RES_L[1]: v = res_reg[1][7:0];
      IDX_RES_H[1]: v = res_reg[1][15:8];
      IDX_RES_L[2]: v = res_reg[2][7:0];
      IDX_RES_H[2]: v = res_reg[2][15:8];
      default: v = RST_BYTE;
    endcase
    rd_byte = v;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wa_idx_reg <= RST_BYTE;
      wdata_reg <= RST_BYTE;
      wstrb_reg <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        wa_idx_reg <= s_axi_awaddr[AW-1:2];
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(wa_idx_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= {24'h00_0000, rd_byte(ar_idx)};
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Plain configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= RST_BYTE;
      rcmp_reg <= CNT_CLEAR;
      cap_en_reg <= '0;
      edge_sel_reg <= '0;
      filt_en_reg <= '0;
      psel_a_reg <= RST_BYTE;
      psel_b_reg <= 4'h0;
      ien_reg <= 2'h0;
    end else begin
      if (wr_to(IDX_MODE)) mode_reg <= wdata_reg & 8'h8f;
      if (wr_to(IDX_RCL)) rcmp_reg[7:0] <= wdata_reg;
      if (wr_to(IDX_RCH)) rcmp_reg[15:8] <= wdata_reg;
      if (wr_to(IDX_CAPEF)) cap_en_reg <= wdata_reg[CAP_EN_LSB +: NUM_CH];
      if (wr_to(IDX_EDGE)) edge_sel_reg <= wdata_reg[2*NUM_CH-1:0];
      if (wr_to(IDX_FILT)) filt_en_reg <= wdata_reg[FILT_EN_LSB +: NUM_CH];
      if (wr_to(IDX_PSA)) psel_a_reg <= wdata_reg;
      if (wr_to(IDX_PSB)) psel_b_reg <= wdata_reg[3:0];
      if (wr_to(IDX_IEN)) ien_reg <= wdata_reg[1:0];
    end
  end

  // Pins come from outside the clock domain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= capture_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire [3:0] psel [NUM_CH] = '{psel_a_reg[3:0], psel_a_reg[7:4], psel_b_reg};

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [FILT_W-1:0] f_cnt_reg;
    logic f_lvl_reg, prev_reg;
    wire [3:0] pidx = (psel[i] <= PIN_SEL_MAX) ? psel[i] : 4'h0;
    wire trcc_edge_t esel = trcc_edge_t'(edge_sel_reg[2*i +: 2]);
    wire rise = f_lvl_reg & ~prev_reg;
    wire fall = ~f_lvl_reg & prev_reg;
    wire hit = (esel == TRCC_EDGE_FALL) ? fall :
               (esel == TRCC_EDGE_RISE) ? rise :
               (esel == TRCC_EDGE_BOTH) ? (rise | fall) : 1'b0;
    assign sel_pin[i] = pin_s2_reg[pidx];
    assign f_lvl[i] = f_lvl_reg;
    assign cap_ev[i] = cap_en_reg[i] & hit;

    // The filter level moves only after the new level held for the full count.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        f_cnt_reg <= '0;
        f_lvl_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else begin
        prev_reg <= f_lvl_reg;
        if (!filt_en_reg[i] || sel_pin[i] == f_lvl_reg) begin
          f_cnt_reg <= '0;
          if (!filt_en_reg[i]) f_lvl_reg <= sel_pin[i];
        end else if (f_cnt_reg == FILT_W'(FILT_CYC - 1)) begin
          f_cnt_reg <= '0;
          f_lvl_reg <= sel_pin[i];
        end else begin
          f_cnt_reg <= f_cnt_reg + 1'b1;
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        res_reg[i] <= CNT_CLEAR;
      end else if (cap_ev[i]) begin
        res_reg[i] <= cnt_reg;
      end else begin
        if (wr_to(IDX_RES_L[i])) res_reg[i][7:0] <= wdata_reg;
        if (wr_to(IDX_RES_H[i])) res_reg[i][15:8] <= wdata_reg;
      end
    end
  end

  wire cmp_mode = ctrl_reg[CTRL_MODE];
  wire run = ctrl_reg[CTRL_RUN];
  wire reload_enable = mode_reg[MODE_RELOAD_ENABLE];
  wire capclr = mode_reg[MODE_CAPCLR];
  wire cmpclr = mode_reg[MODE_CMPCLR];
  wire [1:0] trig_sel = mode_reg[MODE_TRIG +: 2];
  wire ovf = run & (cnt_reg == CNT_MAX);
  wire match = cmp_mode & run & (cnt_reg == rcmp_reg);
  // Overflow sits at index 0, so a trigger code picks its source without an out-of-range index.
  wire [NUM_CH:0] trig_src = {cap_ev, ovf};
  wire trig_ev = trig_src[trig_sel];
  wire cap_clr = ~cmp_mode & capclr & (|cap_ev);
  wire do_reload = ~cmp_mode & reload_enable & trig_ev & ~cap_clr;
  wire cmp_clr = cmp_mode & cmpclr & match;
  wire flag_set = cmp_mode ? match : ovf;

  // Every hardware action outranks a byte write landing on the same edge.
  assign cnt_next = cap_clr ? CNT_CLEAR :
                    do_reload ? rcmp_reg :
                    cmp_clr ? CNT_CLEAR :
                    run ? cnt_reg + 16'h0001 :
                    wr_to(IDX_CNTL) ? {cnt_reg[15:8], wdata_reg} :
                    wr_to(IDX_CNTH) ? {wdata_reg, cnt_reg[7:0]} :
                    cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= CNT_CLEAR;
      ctrl_reg <= RST_BYTE;
      cap_flag_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (wr_to(IDX_CTRL)) ctrl_reg <= wdata_reg & 8'h85;
      if (flag_set) ctrl_reg[CTRL_FLAG] <= 1'b1;
      // A flag that sets in the cycle software clears it stays set.
      cap_flag_reg <= (wr_to(IDX_CAPEF) ? wdata_reg[CAP_FLAG_LSB +: NUM_CH]
                       : cap_flag_reg) | cap_ev;
      irq_reg <= (|cap_flag_reg) & ien_reg[IEN_CAP] & ien_reg[IEN_GLOBAL];
    end
  end

  assign capture_irq = irq_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reload;
    do_reload |=> cnt_reg == $past(rcmp_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value not loaded");

  property p_trig_ch1;
    ~cmp_mode && reload_enable && !capclr && trig_sel == 2'h2 && cap_ev[1] |=> cnt_reg == $past(rcmp_reg);
  endproperty
  a_trig_ch1: assert property (p_trig_ch1) else $error("channel 1 trigger did not reload");

  property p_cap_clr;
    ~cmp_mode && capclr && cap_ev[0] |=> cnt_reg == CNT_CLEAR && res_reg[0] == $past(cnt_reg);
  endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("capture auto-clear failed");

  property p_match_flag;
    cmp_mode && run && cnt_reg == rcmp_reg |=> ctrl_reg[CTRL_FLAG];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("compare flag not set");

  property p_cmp_clr;
    cmp_mode && cmpclr && match |=> cnt_reg == CNT_CLEAR;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("compare clear failed");

  property p_filter;
    filt_en_reg[0] && $changed(f_lvl[0]) |-> $past(sel_pin[0], 1) == f_lvl[0] &&
      $past(sel_pin[0], 2) == f_lvl[0] && $past(sel_pin[0], 3) == f_lvl[0] &&
      $past(sel_pin[0], 4) == f_lvl[0] && $past(filt_en_reg[0], 4);
  endproperty
  a_filter: assert property (p_filter) else $error("filter passed a short pulse");

  property p_rsvd_edge;
    edge_sel_reg[1:0] == TRCC_EDGE_RSVD || !cap_en_reg[0] |-> !cap_ev[0];
  endproperty
  a_rsvd_edge: assert property (p_rsvd_edge) else $error("edge taken on reserved or disabled");

  property p_capture;
    cap_ev[2] |=> res_reg[2] == $past(cnt_reg) && cap_flag_reg[2];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value lost");

  property p_flag;
    cap_ev[1] |=> cap_flag_reg[1];
  endproperty
  a_flag: assert property (p_flag) else $error("capture flag not set");

  property p_irq;
    (|cap_flag_reg) && ien_reg == 2'h3 |=> capture_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_no_irq;
    ien_reg[IEN_GLOBAL] == 1'b0 |=> !capture_irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt without global enable");

  c_capture: cover property (cap_ev[0] ##1 cap_flag_reg[0]);
  c_reload: cover property (do_reload);
  c_cmp_clr: cover property (cmp_clr ##1 cnt_reg == CNT_CLEAR);
  c_irq: cover property ($rose(capture_irq));

endmodule // trcc_timer_capture

// ### dv/trcc_pin_model.sv
// Model of the external signal pins that feed the capture channels.
module trcc_pin_model (
  input wire logic aclk,
  output logic [8:0] pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pins idle high, as a pulled-up input would, so every pulse is a low-going excursion.
  initial begin
    pin = 9'h1ff;
  end

  // Inverts one pin for a number of clock cycles; all nine pins are reachable.
  task automatic pulse(input int p, input int n);
    @(posedge aclk);
    pin[p] <= ~pin[p];
    repeat (n) @(posedge aclk);
    pin[p] <= ~pin[p];
    repeat (10) @(posedge aclk);
  endtask
endmodule // trcc_pin_model

// ### dv/test_trcc_timer_capture.sv
// Self-checking testbench for the timer capture block over its register bus.
module test_trcc_timer_capture;
  import trcc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AW-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [AW-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [8:0] capture_pin;
  logic capture_irq;
  int fail_count = 0;
  int compares = 0;

  always #5 aclk = ~aclk;

  trcc_timer_capture trcc_timer_capture_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_pin(capture_pin), .capture_irq(capture_irq)
  );

  trcc_pin_model trcc_pin_model_i (
    .aclk(aclk),
    .pin(capture_pin)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Address and data are offered together; each is released at the edge that takes it.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    chk(rdata, {24'h000000, exp});
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic set_cnt(input logic [15:0] v);
    wr(IDX_CNTL, v[7:0], RESP_OKAY);
    wr(IDX_CNTH, v[15:8], RESP_OKAY);
  endtask

  // Pin wired to each channel by the pin-select values written below.
  int chpin [3] = '{3, 5, 8};

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    results();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_EDGE, 8'h00, RESP_OKAY);
    rd(IDX_FILT, 8'h00, RESP_OKAY);
    rd(8'he5, 8'h00, RESP_OKAY);
    rd(8'h50, 8'h00, RESP_SLVERR);
    wr(8'h50, 8'h5a, RESP_SLVERR);
    set_cnt(16'h1234);
    rd(IDX_CNTL, 8'h34, RESP_OKAY);
    rd(IDX_CNTH, 8'h12, RESP_OKAY);
    wr(IDX_PSA, 8'h53, RESP_OKAY);
    wr(IDX_PSB, 8'h08, RESP_OKAY);
    wr(IDX_EDGE, 8'h24, RESP_OKAY);
    trcc_pin_model_i.pulse(3, 6);
    rd(IDX_CAPEF, 8'h00, RESP_OKAY);
    wr(IDX_CAPEF, 8'h70, RESP_OKAY);
    // Channel 0 falling, 1 rising, 2 either; the stopped counter makes the result exact.
    for (int c = 0; c < 3; c++) begin
      trcc_pin_model_i.pulse(chpin[c], 6);
      rd(IDX_RES_L[c], 8'h34, RESP_OKAY);
      rd(IDX_RES_H[c], 8'h12, RESP_OKAY);
      rd(IDX_CAPEF, 8'h70 | 8'((2 << c) - 1), RESP_OKAY);
    end
    chk({31'h0, capture_irq}, 32'h0);
    wr(IDX_IEN, 8'h02, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, capture_irq}, 32'h0);
    wr(IDX_IEN, 8'h03, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, capture_irq}, 32'h1);
    rd(IDX_CAPEF, 8'h77, RESP_OKAY);
    wr(IDX_CAPEF, 8'h70, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, capture_irq}, 32'h0);
    wr(IDX_FILT, 8'h10, RESP_OKAY);
    trcc_pin_model_i.pulse(3, 3);
    rd(IDX_CAPEF, 8'h70, RESP_OKAY);
    // Exactly four low samples is the shortest pulse the filter must pass.
    trcc_pin_model_i.pulse(3, 4);
    rd(IDX_CAPEF, 8'h71, RESP_OKAY);
    wr(IDX_CAPEF, 8'h70, RESP_OKAY);
    // The reserved edge code must take no edge at all.
    wr(IDX_EDGE, 8'h27, RESP_OKAY);
    trcc_pin_model_i.pulse(3, 6);
    rd(IDX_CAPEF, 8'h70, RESP_OKAY);
    wr(IDX_EDGE, 8'h24, RESP_OKAY);
    wr(IDX_RCL, 8'hcd, RESP_OKAY);
    wr(IDX_RCH, 8'hab, RESP_OKAY);
    // A non-selected channel must not reload; the selected one must.
    for (int c = 0; c < 3; c++) begin
      set_cnt(16'h0000);
      wr(IDX_MODE, 8'h80 | 8'(c + 1), RESP_OKAY);
      trcc_pin_model_i.pulse(chpin[(c + 1) % 3], 6);
      rd(IDX_CNTH, 8'h00, RESP_OKAY);
      trcc_pin_model_i.pulse(chpin[c], 6);
      rd(IDX_CNTL, 8'hcd, RESP_OKAY);
      rd(IDX_CNTH, 8'hab, RESP_OKAY);
    end
    set_cnt(16'h1234);
    wr(IDX_MODE, 8'h89, RESP_OKAY);
    trcc_pin_model_i.pulse(3, 6);
    rd(IDX_RES_H[0], 8'h12, RESP_OKAY);
    rd(IDX_CNTL, 8'h00, RESP_OKAY);
    rd(IDX_CNTH, 8'h00, RESP_OKAY);
    set_cnt(16'hfffa);
    wr(IDX_MODE, 8'h80, RESP_OKAY);
    wr(IDX_CTRL, 8'h04, RESP_OKAY);
    repeat (20) @(posedge aclk);
    // Writing the flag bit as one stops the counter without clearing the flag.
    wr(IDX_CTRL, 8'h80, RESP_OKAY);
    rd(IDX_CNTH, 8'hab, RESP_OKAY);
    rd(IDX_CTRL, 8'h80, RESP_OKAY);
    // Compare at 0x0100; without the auto-clear the high byte would have moved on.
    wr(IDX_RCL, 8'h00, RESP_OKAY);
    wr(IDX_RCH, 8'h01, RESP_OKAY);
    set_cnt(16'h0000);
    wr(IDX_MODE, 8'h04, RESP_OKAY);
    wr(IDX_CTRL, 8'h05, RESP_OKAY);
    repeat (300) @(posedge aclk);
    wr(IDX_CTRL, 8'h81, RESP_OKAY);
    rd(IDX_CTRL, 8'h81, RESP_OKAY);
    rd(IDX_CNTH, 8'h00, RESP_OKAY);
    results();
  end
endmodule // test_trcc_timer_capture
